//--- design/hpb_pkg.sv
package hpb_pkg;
	// Address and data widths of the parallel port
	localparam int HPB_ADDR_W = 8;
	localparam int HPB_DATA_W = 16;
	localparam int HPB_BYTE_W = 8;
	// Bus style codes seen on the style-select input
	localparam logic HPB_STYLE_SEP = 1'b0;
	localparam logic HPB_STYLE_STROBE = 1'b1;
	// Width codes seen on the width-select input
	localparam logic HPB_WIDTH_8 = 1'b0;
	localparam logic HPB_WIDTH_16 = 1'b1;
	// Direction input level that means a read in the data-strobe style
	localparam logic HPB_DIR_READ = 1'b1;
	// Pull-high value driven onto unused upper data lines
	localparam logic [7:0] HPB_UPPER_PULL = 8'hFF;
	// Reset value of the latched address
	localparam logic [7:0] HPB_ADDR_RST = 8'h00;
	// Access state machine codes, one-hot
	typedef enum logic [2:0] {
		HPB_IDLE = 3'b001,
		HPB_READ = 3'b010,
		HPB_WRITE = 3'b100
	} hpb_state_t;
endpackage

//--- design/hpb_addr_latch.sv
`timescale 1ns/1ps
// Captures the register address on the falling edge of the latch strobe
module hpb_addr_latch
	import hpb_pkg::*;
(
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rst_i,
	// Address side
	input wire logic addr_latch_i,
	input wire logic [HPB_ADDR_W-1:0] addr_i,
	// Latched address
	output logic [HPB_ADDR_W-1:0] addr_o
);
	logic ale_d_ff;
	logic [HPB_ADDR_W-1:0] addr_ff;
	wire ale_fall = ale_d_ff & ~addr_latch_i;
	// Strobe history starts high, as the pin idles pulled up
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			ale_d_ff <= 1'b1;
			addr_ff <= HPB_ADDR_RST;
		end else begin
			ale_d_ff <= addr_latch_i;
			if (ale_fall) begin
				addr_ff <= addr_i; // RQ1
			end
		end
	end
	// With the strobe held high the address pins pass straight through
	assign addr_o = (ale_d_ff & addr_latch_i) ? addr_i : addr_ff; // RQ2
endmodule // hpb_addr_latch

//--- design/hpb_host_port.sv
`timescale 1ns/1ps
// Behaviour
// (RQ1) Capture eight-bit address on falling edge of the latch strobe.
// (RQ2) Latch strobe held high means address inputs are used directly.
// (RQ3) First style: selected read strobe drives addressed register onto data bus.
// (RQ4) First style: selected write strobe loads addressed register from data bus.
// (RQ5) Second style: one data strobe times every read and write.
// (RQ6) Second style: direction input tells read from write.
// (RQ7) Style-select low picks separate strobes, high picks data strobe.
// (RQ8) Only take part in accesses while active-low select is low. A write strobe still held when select rises is committed in that cycle.
// (RQ9) Width select: 8-bit low byte or 16-bit; 8-bit upper lines read high.
// (RQ10) Second style: direction high is read, low is write.
module hpb_host_port
	import hpb_pkg::*;
#(
	parameter int ADDR_W = HPB_ADDR_W,
	parameter int DATA_W = HPB_DATA_W
) (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rst_i,
	// Mode straps
	input wire logic bus_style_select_i,
	input wire logic bus_width_select_i,
	// Processor control strobes, active low except the latch strobe
	input wire logic chip_sel_n_i,
	input wire logic addr_latch_i,
	input wire logic read_n_i,
	input wire logic write_n_i,
	// Processor address and data
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [DATA_W-1:0] data_i,
	output logic [DATA_W-1:0] data_o,
	output logic data_oe_n_o,
	// Register file side
	output logic [ADDR_W-1:0] reg_addr_o,
	output logic reg_rd_o,
	output logic reg_wr_o,
	output logic [DATA_W-1:0] reg_wdata_o,
	input wire logic [DATA_W-1:0] reg_rdata_i
);
	hpb_state_t state_ff;
	hpb_state_t nxt_state;
	logic [DATA_W-1:0] rdata_ff;
	logic [DATA_W-1:0] wdata_ff;
	logic [ADDR_W-1:0] addr_lat;

	// Fold bus width onto a data word: 8-bit mode forces upper byte high
	function automatic logic [DATA_W-1:0] fold_width(input logic wide, input logic [DATA_W-1:0] d);
		fold_width = wide ? d : {HPB_UPPER_PULL, d[HPB_BYTE_W-1:0]}; // RQ9
	endfunction

	hpb_addr_latch hpb_addr_latch_inst (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.addr_latch_i(addr_latch_i),
		.addr_i(addr_i),
		.addr_o(addr_lat)
	);

	// Strobe decode for both styles; pins stay named by first-style role
	wire selected = ~chip_sel_n_i; // RQ8
	wire style_strobe = (bus_style_select_i == HPB_STYLE_STROBE); // RQ7
	wire data_strobe = ~read_n_i; // RQ5
	wire dir_read = (write_n_i == HPB_DIR_READ); // RQ6 RQ10
	wire rd_req = selected & (style_strobe ? (data_strobe & dir_read) : ~read_n_i); // RQ3
	wire wr_req = selected & (style_strobe ? (data_strobe & ~dir_read) : ~write_n_i); // RQ4
	wire wide = (bus_width_select_i == HPB_WIDTH_16);

	// One register access per strobe; a write commits on the strobe's end
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			HPB_IDLE: begin
				if (rd_req) nxt_state = HPB_READ;
				else if (wr_req) nxt_state = HPB_WRITE;
			end
			HPB_READ: begin
				if (!rd_req) nxt_state = HPB_IDLE;
			end
			HPB_WRITE: begin
				if (!wr_req) nxt_state = HPB_IDLE;
			end
			default: nxt_state = HPB_IDLE;
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			state_ff <= HPB_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Read data follows the register while the strobe is held
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			rdata_ff <= '0;
			wdata_ff <= '0;
		end else begin
			if (rd_req) rdata_ff <= fold_width(wide, reg_rdata_i); // RQ3 RQ9
			if (wr_req) wdata_ff <= fold_width(wide, data_i); // RQ4 RQ9
		end
	end

	// Drivers on only during a selected read that has been served
	assign data_oe_n_o = ~(rd_req & (state_ff == HPB_READ)); // RQ3 RQ8
	assign data_o = rdata_ff;
	assign reg_addr_o = addr_lat;
	assign reg_rd_o = rd_req & (state_ff == HPB_IDLE);
	// Write strobe ends: data captured in the last held cycle is committed
	assign reg_wr_o = (state_ff == HPB_WRITE) & ~wr_req; // RQ4
	assign reg_wdata_o = wdata_ff;

	// Checks; each guards one step of the strobe walk, so a stuck state
	// machine shows up as a missed cycle, not only as a wrong final count
	sequence s_rd_hold;
		rd_req ##1 rd_req;
	endsequence
	sequence s_wr_hold;
		wr_req ##1 !wr_req;
	endsequence

	// Read strobe held past its first cycle has the drivers on
	property p_rd_drive;
		@(posedge core_clk_i) disable iff (rst_i)
		s_rd_hold |-> !data_oe_n_o;
	endproperty
	a_rd_drive: assert property (p_rd_drive) else $error("read not driven"); // RQ3

	// The register file sees one read request per strobe
	property p_rd_pulse;
		@(posedge core_clk_i) disable iff (rst_i)
		reg_rd_o |=> !reg_rd_o;
	endproperty
	a_rd_pulse: assert property (p_rd_pulse) else $error("read request repeated"); // RQ3

	// Pins carry the register sampled one cycle earlier
	property p_rd_data;
		@(posedge core_clk_i) disable iff (rst_i)
		(s_rd_hold ##0 wide) |-> data_o == $past(reg_rdata_i);
	endproperty
	a_rd_data: assert property (p_rd_data) else $error("read data wrong"); // RQ3

	// Drivers drop in the cycle the strobe or select goes away
	property p_rd_release;
		@(posedge core_clk_i) disable iff (rst_i)
		!rd_req |-> data_oe_n_o;
	endproperty
	a_rd_release: assert property (p_rd_release) else $error("drivers left on"); // RQ3

	// Deselected: no drivers, no register read request
	property p_desel;
		@(posedge core_clk_i) disable iff (rst_i)
		chip_sel_n_i |-> (data_oe_n_o && !reg_rd_o);
	endproperty
	a_desel: assert property (p_desel) else $error("acted while deselected"); // RQ8

	// A select held off for two cycles leaves no write to commit
	property p_desel_wr;
		@(posedge core_clk_i) disable iff (rst_i)
		(chip_sel_n_i && $past(chip_sel_n_i)) |-> !reg_wr_o;
	endproperty
	a_desel_wr: assert property (p_desel_wr) else $error("write while deselected"); // RQ8

	// Commit lands in the cycle the write strobe ends
	property p_wr_commit;
		@(posedge core_clk_i) disable iff (rst_i)
		s_wr_hold |-> reg_wr_o;
	endproperty
	a_wr_commit: assert property (p_wr_commit) else $error("write not committed"); // RQ4

	// Exactly one commit per strobe
	property p_wr_pulse;
		@(posedge core_clk_i) disable iff (rst_i)
		reg_wr_o |=> !reg_wr_o;
	endproperty
	a_wr_pulse: assert property (p_wr_pulse) else $error("write committed twice"); // RQ4

	// Committed word is the bus data of the strobe's last cycle
	property p_wr_data;
		@(posedge core_clk_i) disable iff (rst_i)
		(s_wr_hold ##0 wide) |-> reg_wdata_o == $past(data_i);
	endproperty
	a_wr_data: assert property (p_wr_data) else $error("write data wrong"); // RQ4

	// Narrow reads show the pulled-high upper lines
	property p_narrow;
		@(posedge core_clk_i) disable iff (rst_i)
		(!wide && $past(rd_req)) |-> data_o[DATA_W-1:HPB_BYTE_W] == HPB_UPPER_PULL;
	endproperty
	a_narrow: assert property (p_narrow) else $error("upper byte not high"); // RQ9

	// Narrow writes ignore the open upper lines
	property p_narrow_wr;
		@(posedge core_clk_i) disable iff (rst_i)
		(s_wr_hold ##0 !wide) |-> reg_wdata_o[DATA_W-1:HPB_BYTE_W] == HPB_UPPER_PULL;
	endproperty
	a_narrow_wr: assert property (p_narrow_wr) else $error("upper write byte not high"); // RQ9

	// Strobe style with direction low is a write, never a read
	property p_strobe_dir;
		@(posedge core_clk_i) disable iff (rst_i)
		(style_strobe && selected && !read_n_i && !write_n_i) |-> (wr_req && !rd_req);
	endproperty
	a_strobe_dir: assert property (p_strobe_dir) else $error("direction misread"); // RQ6 RQ10

	// Strobe style: nothing happens without the data strobe
	property p_strobe_only;
		@(posedge core_clk_i) disable iff (rst_i)
		(style_strobe && read_n_i) |-> (!rd_req && !wr_req);
	endproperty
	a_strobe_only: assert property (p_strobe_only) else $error("access without strobe"); // RQ5

	// Separate style: the write strobe alone starts a write
	property p_sep;
		@(posedge core_clk_i) disable iff (rst_i)
		(!style_strobe && selected && !write_n_i) |-> wr_req;
	endproperty
	a_sep: assert property (p_sep) else $error("style select ignored"); // RQ7

	// Latch strobe fall captures the address for the access
	property p_latch;
		@(posedge core_clk_i) disable iff (rst_i)
		($fell(addr_latch_i) ##1 !addr_latch_i) |-> reg_addr_o == $past(addr_i, 1);
	endproperty
	a_latch: assert property (p_latch) else $error("address not latched"); // RQ1

	// Latch strobe held high passes the address pins straight through
	property p_addr_pass;
		@(posedge core_clk_i) disable iff (rst_i)
		($past(addr_latch_i) && addr_latch_i) |-> reg_addr_o == addr_i;
	endproperty
	a_addr_pass: assert property (p_addr_pass) else $error("address not passed through"); // RQ2
endmodule // hpb_host_port

//--- bench/hpb_cpu.sv
`timescale 1ns/1ps
// Processor side; pins move 1 ns after an edge
module hpb_cpu
	import hpb_pkg::*;
(
	// Clock
	input wire logic core_clk_i,
	// Bus pins
	output logic cs_n_o,
	output logic ale_o,
	output logic rd_n_o,
	output logic wr_n_o,
	output logic [7:0] a_o,
	output logic [15:0] d_o,
	// Port read data
	input wire logic [15:0] d_i
);
	// Idle bus: deselected, strobes and latch strobe high
	initial begin
		cs_n_o = 1'b1;
		ale_o = 1'b1;
		rd_n_o = 1'b1;
		wr_n_o = 1'b1;
		a_o = 8'h00;
		d_o = 16'h0000;
	end
	// Released pins show inverted values so a stale latch cannot pass
	task automatic acc(input logic st, sn, mx, rd, input logic [7:0] a, input logic [15:0] wd,
		output logic [15:0] q);
		@(posedge core_clk_i) #1;
		cs_n_o = sn;
		a_o = a;
		d_o = wd;
		if (mx) begin
			@(posedge core_clk_i) #1;
			ale_o = 1'b0;
			@(posedge core_clk_i) #1;
			a_o = ~a;
		end
		rd_n_o = st ? 1'b0 : !rd;
		wr_n_o = rd;
		repeat (3) @(posedge core_clk_i);
		q = d_i;
		#1;
		rd_n_o = 1'b1;
		wr_n_o = 1'b1;
		repeat (2) @(posedge core_clk_i);
		#1;
		cs_n_o = 1'b1;
		ale_o = 1'b1;
		a_o = ~a;
		d_o = ~wd;
	endtask
endmodule // hpb_cpu

//--- bench/hpb_host_port_tb.sv
`timescale 1ns/1ps
// Register contents are the address and its inverse, so a wrong address shows
module hpb_host_port_tb
	import hpb_pkg::*;
;
	logic core_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic sty = HPB_STYLE_SEP;
	logic wid = HPB_WIDTH_16;
	logic cs_n, ale, rd_n, wr_n, oe_n, rd, wr;
	logic [7:0] a, ra, wa;
	logic [15:0] d, dq, wd, wdat, q;
	int num_errors = 0, cmp_count = 0, wn = 0, rn = 0, on = 0, cyc = 0;
	wire logic [15:0] rdat = {~ra, ra};
	always #5 core_clk_i = ~core_clk_i;
	hpb_host_port hpb_host_port_inst (.core_clk_i(core_clk_i), .rst_i(rst_i), .bus_style_select_i(sty),
		.bus_width_select_i(wid), .chip_sel_n_i(cs_n), .addr_latch_i(ale), .read_n_i(rd_n), .write_n_i(wr_n),
		.addr_i(a), .data_i(d), .data_o(dq), .data_oe_n_o(oe_n), .reg_addr_o(ra), .reg_rd_o(rd),
		.reg_wr_o(wr), .reg_wdata_o(wd), .reg_rdata_i(rdat));
	hpb_cpu hpb_cpu_inst (.core_clk_i(core_clk_i), .cs_n_o(cs_n), .ale_o(ale), .rd_n_o(rd_n),
		.wr_n_o(wr_n), .a_o(a), .d_o(d), .d_i(dq));
	// Pulse monitor; the cycle ceiling cuts a hang short
	always @(posedge core_clk_i) begin
		cyc <= cyc + 1;
		rn <= rn + (rd === 1'b1);
		on <= on + (oe_n === 1'b0);
		if (wr === 1'b1) begin
			wn <= wn + 1;
			wa <= ra;
			wdat <= wd;
		end
		if (cyc == 3000) begin
			num_errors++;
			tally_and_finish();
		end
	end
	task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic wchk(input logic mx, input logic [7:0] ad, input logic [15:0] v, input logic [15:0] e);
		int n;
		n = wn;
		hpb_cpu_inst.acc(sty, 1'b0, mx, 1'b0, ad, v, q);
		chk("writes", 16'(n + 1), 16'(wn));
		chk("waddr", {8'h00, ad}, {8'h00, wa});
		chk("wdata", e, wdat);
	endtask
	task automatic rchk(input logic mx, input logic [7:0] ad, input logic [15:0] e);
		int n;
		int m;
		n = rn;
		m = on;
		hpb_cpu_inst.acc(sty, 1'b0, mx, 1'b1, ad, 16'h0000, q);
		chk("rdata", e, q);
		chk("reads", 16'(n + 1), 16'(rn));
		chk("driven", 16'h0001, 16'(on > m));
		chk("released", 16'h0001, {15'h0000, oe_n});
	endtask
	task automatic t_sep();
		wchk(1'b0, 8'h5A, 16'hA55A, 16'hA55A);
		rchk(1'b0, 8'hC3, 16'h3CC3);
		$display("test sep done");
	endtask
	task automatic t_strobe();
		sty = HPB_STYLE_STROBE;
		wchk(1'b0, 8'h81, 16'h1234, 16'h1234);
		rchk(1'b0, 8'h0F, 16'hF00F);
		sty = HPB_STYLE_SEP;
		$display("test strobe done");
	endtask
	task automatic t_mux();
		rchk(1'b1, 8'h96, 16'h6996);
		wchk(1'b1, 8'hE1, 16'hBEEF, 16'hBEEF);
		$display("test mux done");
	endtask
	task automatic t_w8();
		wid = HPB_WIDTH_8;
		rchk(1'b0, 8'h42, {HPB_UPPER_PULL, 8'h42});
		wchk(1'b0, 8'h24, 16'h5566, {HPB_UPPER_PULL, 8'h66});
		wid = HPB_WIDTH_16;
		$display("test w8 done");
	endtask
	task automatic t_desel();
		int n;
		n = rn + wn + on;
		hpb_cpu_inst.acc(sty, 1'b1, 1'b0, 1'b1, 8'h11, 16'h2222, q);
		hpb_cpu_inst.acc(sty, 1'b1, 1'b0, 1'b0, 8'h33, 16'h4444, q);
		chk("desel", 16'(n), 16'(rn + wn + on));
		$display("test desel done");
	endtask
	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// Reset for ten cycles, then the scenarios
	initial begin
		repeat (10) @(posedge core_clk_i);
		#1;
		rst_i = 1'b0;
		t_sep();
		t_strobe();
		t_mux();
		t_w8();
		t_desel();
		tally_and_finish();
	end
endmodule // hpb_host_port_tb
